// file: hdl/pmc_top.sv
// power-mode controller: cpu and system clock gating for idle and sleep
// How it works
// - cpu clock stops in idle and sleep
// - idle keeps system source and peripherals running
// - idle works from fast internal source
// - idle works from secondary or low-power source
// - sleep stops cpu, peripherals, and the system source unless it is low-power or kept by the usb override
// - self-clocked peripherals run in sleep, wake
// - clock fail monitor off during sleep
// - watchdog count kept on sleep entry
// - wake waits a source-dependent start-up delay
// - usb may keep primary or fast source
// - output pins hold levels in sleep
`timescale 1ns/1ps
module pmc_top
   import pmc_pkg::*;
#(
   parameter int START_PRI_CYC  = PMC_START_PRI_CYC,
   parameter int START_FAST_CYC = PMC_START_FAST_CYC,
   parameter int START_SEC_CYC  = PMC_START_SEC_CYC,
   parameter int START_LOW_CYC  = PMC_START_LOW_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // software control
   input  wire logic        halt_req,
   input  wire logic        sleep_sel,
   input  wire pmc_src_t    sys_src,
   input  wire logic [7:0]  module_dis,
   input  wire logic        usb_keep_osc,
   input  wire logic        fail_mon_en,
   // wake events, from outside the clock domain
   input  wire pmc_wake_t   wake_in,
   // pins to hold
   input  wire logic [7:0]  pin_out_in,
   // clock tree and status
   output pmc_clk_en_t      clk_en,
   output logic [7:0]       module_en,
   output logic             fail_mon_active,
   output logic             watchdog_hold,
   output logic [7:0]       pin_out,
   output pmc_state_t       mode
);

   // start-up counts must fit the wait counter and be non-zero
   if (START_PRI_CYC < 1 || START_FAST_CYC < 1 ||
       START_SEC_CYC < 1 || START_LOW_CYC < 1 ||
       START_PRI_CYC >= (1 << PMC_CNT_W) ||
       START_SEC_CYC >= (1 << PMC_CNT_W) ||
       START_FAST_CYC >= (1 << PMC_CNT_W) ||
       START_LOW_CYC >= (1 << PMC_CNT_W)) begin : g_bad_start
      $error("start-up count out of range");
   end

   // wake synchroniser
   pmc_wake_t wake_s1_reg;
   pmc_wake_t wake_s2_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wake_s1_reg <= '0;
         wake_s2_reg <= '0;
      end else begin
         wake_s1_reg <= wake_in;
         wake_s2_reg <= wake_s1_reg;
      end
   end

   logic wake_any;
   assign wake_any = |wake_s2_reg;

   // mode sequencer
   pmc_state_t              state_reg, state_next;
   logic [PMC_CNT_W-1:0]    cnt_reg, cnt_next;
   logic [PMC_CNT_W-1:0]    start_cyc;

   always_comb begin
      unique case (sys_src)
         PMC_SRC_PRIMARY: start_cyc = PMC_CNT_W'(START_PRI_CYC);
         PMC_SRC_FAST:    start_cyc = PMC_CNT_W'(START_FAST_CYC);
         PMC_SRC_SECOND:  start_cyc = PMC_CNT_W'(START_SEC_CYC);
         PMC_SRC_LOWPWR:  start_cyc = PMC_CNT_W'(START_LOW_CYC);
      endcase
   end

   logic src_kept;
   // usb override keeps primary or fast source alive in sleep
   assign src_kept = usb_keep_osc &&
                     (sys_src == PMC_SRC_PRIMARY ||
                      sys_src == PMC_SRC_FAST);

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         PMC_RUN: begin
            // entry only on software halt request
            if (halt_req) begin
               state_next = sleep_sel ? PMC_SLEEP : PMC_IDLE;
            end
         end
         PMC_IDLE: begin
            if (wake_any) begin
               state_next = PMC_RUN;
            end
         end
         PMC_SLEEP: begin
            if (wake_any) begin
               // source left running needs no start-up wait
               if (src_kept) begin
                  state_next = PMC_RUN;
               end else begin
                  state_next = PMC_WAKE;
                  cnt_next   = start_cyc - PMC_CNT_W'(1);
               end
            end
         end
         PMC_WAKE: begin
            if (cnt_reg == '0) begin
               state_next = PMC_RUN;
            end else begin
               cnt_next = cnt_reg - PMC_CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= PMC_RUN;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // registered outputs
   pmc_clk_en_t   clk_en_reg, clk_en_next;
   logic [7:0]    module_en_reg, module_en_next;
   logic          fail_mon_reg, fail_mon_next;
   logic          wd_hold_reg, wd_hold_next;
   logic [7:0]    pin_out_reg, pin_out_next;

   always_comb begin
      logic run_like;
      logic sys_on;
      run_like = (state_next == PMC_RUN);
      // system source off only in sleep or while restarting
      sys_on   = (state_next == PMC_RUN || state_next == PMC_IDLE) ||
                 src_kept;
      clk_en_next.cpu = run_like;
      // idle keeps peripherals clocked from any source
      clk_en_next.periph = (state_next == PMC_RUN) ||
                           (state_next == PMC_IDLE);
      clk_en_next.primary_osc =
         (sys_src == PMC_SRC_PRIMARY) && sys_on;
      clk_en_next.fast_internal_osc =
         (sys_src == PMC_SRC_FAST) && sys_on;
      clk_en_next.secondary_osc =
         (sys_src == PMC_SRC_SECOND) && sys_on;
      // low-power source stays on: self-clocked wake logic uses it
      clk_en_next.low_power_internal_osc = 1'b1;
      // individual disables honoured in every mode
      module_en_next = ~module_dis;
      fail_mon_next  = fail_mon_en && (state_next != PMC_SLEEP) &&
                       (state_next != PMC_WAKE);
      // watchdog count frozen-free: hold flag only blocks auto-clear
      wd_hold_next   = (state_next == PMC_SLEEP);
      // pins follow drive when running, latch while asleep
      pin_out_next   = (state_next == PMC_SLEEP || state_next == PMC_WAKE)
                       ? pin_out_reg : pin_out_in;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clk_en_reg    <= '{cpu: 1'b1, periph: 1'b1, primary_osc: 1'b1,
                            fast_internal_osc: 1'b0, secondary_osc: 1'b0,
                            low_power_internal_osc: 1'b1};
         module_en_reg <= '0;
         fail_mon_reg  <= 1'b0;
         wd_hold_reg   <= 1'b0;
         pin_out_reg   <= '0;
      end else begin
         clk_en_reg    <= clk_en_next;
         module_en_reg <= module_en_next;
         fail_mon_reg  <= fail_mon_next;
         wd_hold_reg   <= wd_hold_next;
         pin_out_reg   <= pin_out_next;
      end
   end

   assign clk_en          = clk_en_reg;
   assign module_en       = module_en_reg;
   assign fail_mon_active = fail_mon_reg;
   assign watchdog_hold   = wd_hold_reg;
   assign pin_out         = pin_out_reg;
   assign mode            = state_reg;

endmodule

// file: hdl/pmc_pkg.sv
// shared constants and types for the power-mode clock gating block
package pmc_pkg;

   // system clock source selection
   typedef enum logic [1:0] {
      PMC_SRC_PRIMARY = 2'h0,
      PMC_SRC_FAST    = 2'h1,
      PMC_SRC_SECOND  = 2'h2,
      PMC_SRC_LOWPWR  = 2'h3
   } pmc_src_t;

   // power mode, gray in code order run -> idle -> sleep -> wake
   typedef enum logic [1:0] {
      PMC_RUN   = 2'h0,
      PMC_IDLE  = 2'h1,
      PMC_SLEEP = 2'h3,
      PMC_WAKE  = 2'h2
   } pmc_state_t;

   // wake sources from self-clocked peripherals
   typedef struct packed {
      logic change_detect;
      logic watchdog_counter;
      logic converter;
      logic serial_port;
      logic other_irq;
   } pmc_wake_t;

   // clock enables to the clock tree
   typedef struct packed {
      logic cpu;
      logic periph;
      logic primary_osc;
      logic fast_internal_osc;
      logic secondary_osc;
      logic low_power_internal_osc;
   } pmc_clk_en_t;

   // start-up delays per source, in microseconds
   localparam int PMC_CLK_MHZ         = 20;
   localparam int PMC_START_PRI_US    = 1000;
   localparam int PMC_START_FAST_US   = 10;
   localparam int PMC_START_SEC_US    = 2000;
   localparam int PMC_START_LOW_US    = 5;
   localparam int PMC_START_PRI_CYC   = PMC_START_PRI_US * PMC_CLK_MHZ;
   localparam int PMC_START_FAST_CYC  = PMC_START_FAST_US * PMC_CLK_MHZ;
   localparam int PMC_START_SEC_CYC   = PMC_START_SEC_US * PMC_CLK_MHZ;
   localparam int PMC_START_LOW_CYC   = PMC_START_LOW_US * PMC_CLK_MHZ;
   localparam int PMC_CNT_W           = 16;

endpackage

// file: verif/pmc_top_properties.sv
// port assertions for the power-mode clock gating block
`timescale 1ns/1ps
module pmc_props
   import pmc_pkg::*;
#(
   parameter int START_PRI_CYC  = 1,
   parameter int START_FAST_CYC = 1,
   parameter int START_SEC_CYC  = 1,
   parameter int START_LOW_CYC  = 1
) (
   input wire logic        mclk, resetn, halt_req, sleep_sel,
   input wire pmc_src_t    sys_src,
   input wire logic [7:0]  module_dis, pin_out_in, module_en, pin_out,
   input wire logic        usb_keep_osc, fail_mon_en,
   input wire pmc_wake_t   wake_in,
   input wire pmc_clk_en_t clk_en,
   input wire logic        fail_mon_active, watchdog_hold,
   input wire pmc_state_t  mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   int wcnt;
   int lim [4];
   assign lim = '{START_PRI_CYC, START_FAST_CYC, START_SEC_CYC,
                  START_LOW_CYC};
   // cycles spent so far in the start-up wait
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn) wcnt <= 0;
      else wcnt <= (mode == PMC_WAKE) ? wcnt + 1 : 0;
   sequence s_slept2;
      (mode == PMC_SLEEP) [*2];
   endsequence
   sequence s_wake_held;
      (mode == PMC_SLEEP && wake_in != '0) [*3];
   endsequence
   chk_cpu_gated: assert property (mode != PMC_RUN |-> !clk_en.cpu)
      else $error("cpu clock on while halted");
   chk_idle_clocks: assert property (mode == PMC_IDLE |->
      clk_en.periph && clk_en[3 - sys_src]) else $error("idle clocks off");
   chk_sleep_stops: assert property (mode == PMC_SLEEP |->
      !clk_en.periph && clk_en.low_power_internal_osc)
      else $error("sleep clocks wrong");
   chk_wake_event: assert property (s_wake_held |=> mode != PMC_SLEEP)
      else $error("no wake from sleep");
   chk_monitor_off: assert property (mode == PMC_SLEEP |-> !fail_mon_active)
      else $error("monitor active in sleep");
   chk_wdog_kept: assert property (mode == PMC_SLEEP |-> watchdog_hold)
      else $error("watchdog not held");
   chk_wake_len: assert property (mode == PMC_WAKE |-> wcnt < lim[sys_src])
      else $error("start-up wait too long");
   chk_pins_held: assert property (s_slept2 |-> $stable(pin_out))
      else $error("pins changed in sleep");
   chk_halt_entry: assert property (mode == PMC_RUN && halt_req |=>
      mode == ($past(sleep_sel) ? PMC_SLEEP : PMC_IDLE))
      else $error("wrong halt mode");
   chk_no_self: assert property (mode == PMC_RUN && !halt_req |=>
      mode == PMC_RUN) else $error("halt without request");
endmodule
bind pmc_top pmc_props #(.START_PRI_CYC(START_PRI_CYC),
   .START_FAST_CYC(START_FAST_CYC), .START_SEC_CYC(START_SEC_CYC),
   .START_LOW_CYC(START_LOW_CYC)) u_pmc_props (.*);

// file: verif/power_mode_clock_gating_bench.sv
// self-checking bench for the power-mode clock gating block
`timescale 1ns/1ps
module power_mode_clock_gating_bench;
   import pmc_pkg::*;
   logic        mclk = 0, resetn = 0, halt_req = 0, sleep_sel = 0;
   logic        usb_keep_osc = 0, fail_mon_en = 1;
   pmc_src_t    sys_src = PMC_SRC_PRIMARY;
   logic [7:0]  module_dis = 8'h00, pin_out_in = 8'h3c, module_en, pin_out;
   pmc_wake_t   wake_in = '0;
   pmc_clk_en_t clk_en;
   logic        fail_mon_active, watchdog_hold;
   pmc_state_t  mode;
   int          num_errors = 0, total_checks = 0;
   int          dly [4] = '{5, 3, 6, 4};
   always #25 mclk = ~mclk;
   pmc_top #(.START_PRI_CYC(5), .START_FAST_CYC(3), .START_SEC_CYC(6),
      .START_LOW_CYC(4)) u_pmc_top (.mclk, .resetn, .halt_req, .sleep_sel,
      .sys_src, .module_dis, .usb_keep_osc, .fail_mon_en, .wake_in,
      .pin_out_in, .clk_en, .module_en, .fail_mon_active, .watchdog_hold,
      .pin_out, .mode);
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp_bit(input logic g, e, input string m);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task automatic cmp_byte(input logic [7:0] g, e, input string m);
      cmp_bit(g === e, 1'b1, m);
   endtask
   task automatic enter(input logic slp, input pmc_src_t s);
      @(posedge mclk);
      sys_src <= s;
      sleep_sel <= slp;
      halt_req <= 1'b1;
      @(posedge mclk);
      halt_req <= 1'b0;
      @(negedge mclk);
   endtask
   // holds one wake line until run, counting start-up cycles
   task automatic wake_up(input int b, output int n);
      n = 0;
      @(posedge mclk);
      wake_in <= pmc_wake_t'(5'h01 << b);
      for (int i = 0; i < 60 && mode !== PMC_RUN; i++) begin
         @(negedge mclk);
         n += int'(mode === PMC_WAKE);
      end
      @(posedge mclk);
      wake_in <= '0;
      @(negedge mclk);
   endtask
   task automatic t_idle(input pmc_src_t s);
      int n;
      enter(1'b0, s);
      cmp_byte({6'h00, mode}, 8'h01, "not idle");
      cmp_bit(clk_en.cpu, 1'b0, "cpu on");
      cmp_bit(clk_en.periph & clk_en[3 - s], 1'b1, "clock off");
      wake_up(s, n);
      cmp_bit(clk_en.cpu, 1'b1, "cpu off");
   endtask
   task automatic t_sleep(input pmc_src_t s);
      logic [7:0] p;
      int n;
      @(posedge mclk);
      module_dis <= 8'ha5;
      enter(1'b1, s);
      cmp_byte({6'h00, mode}, 8'h03, "not asleep");
      cmp_bit(clk_en.periph | clk_en[3 - s], s == PMC_SRC_LOWPWR, "clk");
      cmp_bit(fail_mon_active | !watchdog_hold, 1'b0, "mon");
      p = pin_out;
      @(posedge mclk);
      pin_out_in <= ~pin_out_in;
      repeat (3) @(negedge mclk);
      cmp_byte(pin_out, p, "pins");
      cmp_byte(module_en, 8'h5a, "enables");
      wake_up(4 - s, n);
      cmp_byte(8'(n), 8'(dly[s]), "delay");
      cmp_bit(fail_mon_active, 1'b1, "mon off");
   endtask
   task automatic t_usb();
      int n;
      @(posedge mclk);
      usb_keep_osc <= 1'b1;
      enter(1'b1, PMC_SRC_FAST);
      cmp_bit(clk_en.fast_internal_osc, 1'b1, "usb source");
      wake_up(4, n);
      cmp_byte(8'(n), 8'h00, "usb delay");
   endtask
   initial begin
      #100000;
      $display("FAIL %0t timeout", $time);
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(negedge mclk);
      cmp_byte({6'h00, mode}, 8'h00, "left run");
      for (int s = 0; s < 4; s++) t_idle(pmc_src_t'(s[1:0]));
      for (int s = 0; s < 4; s++) t_sleep(pmc_src_t'(s[1:0]));
      t_usb();
      report_and_stop();
   end
endmodule
